// file: hdl/twm_params.svh
// Register offsets, field positions, reset values and status codes of the two-wire master
`ifndef TWM_PARAMS_SVH
`define TWM_PARAMS_SVH

// Register indices on the plain register port
`define TWM_REG_CTRL 2'h0
`define TWM_REG_STAT 2'h1
`define TWM_REG_DATA 2'h2
`define TWM_REG_RATE 2'h3

// Control register field positions
`define TWM_CTL_DONE 7
`define TWM_CTL_ACK 6
`define TWM_CTL_STA 5
`define TWM_CTL_STO 4
`define TWM_CTL_WCOL 3
`define TWM_CTL_EN 2
`define TWM_CTL_IE 0

// Status register layout: code in 7:3, prescaler in 1:0
`define TWM_STAT_CODE_LSB 3
`define TWM_STAT_MASK 8'hF8

// Status codes, prescaler bits zero
`define TWM_ST_START 8'h08
`define TWM_ST_RSTART 8'h10
`define TWM_ST_AW_ACK 8'h18
`define TWM_ST_AW_NACK 8'h20
`define TWM_ST_DATA_ACK 8'h28
`define TWM_ST_DATA_NACK 8'h30
`define TWM_ST_ARB_LOST 8'h38
`define TWM_ST_AR_ACK 8'h40
`define TWM_ST_AR_NACK 8'h48
`define TWM_ST_NONE 8'hF8

// Reset values
`define TWM_RST_CTRL 8'h00
`define TWM_RST_DATA 8'hFF
`define TWM_RST_RATE 8'h01
`define TWM_RST_PRESC 2'h0

`endif

// file: hdl/twm_pkg.sv
// Types shared by the two-wire master sequencer and its bit engine
package twm_pkg;

    // Commands from the sequencer to the bit engine
    typedef enum logic [1:0] {
        TWM_CMD_NONE,
        TWM_CMD_START,
        TWM_CMD_STOP,
        TWM_CMD_WRITE
    } twm_cmd_t;

    // Operating modes of the unit
    typedef enum logic [2:0] {
        TWM_MODE_IDLE,
        TWM_MODE_MT,
        TWM_MODE_MR,
        TWM_MODE_ST,
        TWM_MODE_SR
    } twm_mode_t;

    // Sequencer states
    typedef enum logic [2:0] {
        TWM_SEQ_IDLE,
        TWM_SEQ_WAIT_FREE,
        TWM_SEQ_START,
        TWM_SEQ_STOP,
        TWM_SEQ_ADDR,
        TWM_SEQ_DATA
    } twm_seq_t;

    // Bit engine states
    typedef enum logic [1:0] {
        TWM_ENG_IDLE,
        TWM_ENG_START,
        TWM_ENG_STOP,
        TWM_ENG_WRITE
    } twm_eng_t;

endpackage

// file: hdl/twm_bit_engine.sv
// Bit engine of the two-wire master: START, STOP and byte transmit with acknowledge
`timescale 1ns/10ps
`default_nettype none

module twm_bit_engine
    import twm_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Control from the sequencer
    input wire logic enable,
    input wire logic tick,
    input wire logic cmd_valid,
    input wire twm_cmd_t cmd,
    input wire logic [7:0] tx_byte,
    output logic done,
    output logic ack_seen,
    output logic arb_lost,
    output logic bus_busy,
    // Serial clock pin
    input wire logic scl_sense,
    output logic scl_val,
    output logic scl_oe,
    // Serial data pin
    input wire logic sda_sense,
    output logic sda_val,
    output logic sda_oe
);

    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic sda_prev_q;
    logic busy_q;
    twm_eng_t state_q;
    logic [1:0] phase_q;
    logic [3:0] bit_q;
    logic [8:0] shift_q;
    logic scl_low_q;
    logic sda_low_q;
    logic done_q;
    logic ack_q;
    logic arb_q;
    logic scl_s;
    logic sda_s;

    assign scl_s = scl_sync_q[1];
    assign sda_s = sda_sync_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and bus-free watch

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            sda_prev_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_sense};
            sda_sync_q <= {sda_sync_q[0], sda_sense};
            sda_prev_q <= sda_s;
        end
    end

    // Busy from any START seen on the wires until any STOP
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
        end else if (scl_s && sda_prev_q && !sda_s) begin
            busy_q <= 1'b1;
        end else if (scl_s && !sda_prev_q && sda_s) begin
            busy_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Condition and byte sequencer, four quarter-bit phases per condition or bit

    always_ff @(posedge ref_clk) begin
        if (!rst_n || !enable) begin
            state_q <= TWM_ENG_IDLE;
            phase_q <= 2'h0;
            bit_q <= 4'h0;
            shift_q <= 9'h1FF;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
            done_q <= 1'b0;
            ack_q <= 1'b0;
            arb_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            arb_q <= 1'b0;
            unique case (state_q)
                TWM_ENG_IDLE: begin
                    phase_q <= 2'h0;
                    bit_q <= 4'h0;
                    shift_q <= {tx_byte, 1'b1};
                    if (cmd_valid && cmd == TWM_CMD_START) begin
                        state_q <= TWM_ENG_START;
                    end else if (cmd_valid && cmd == TWM_CMD_STOP) begin
                        state_q <= TWM_ENG_STOP;
                    end else if (cmd_valid && cmd == TWM_CMD_WRITE) begin
                        state_q <= TWM_ENG_WRITE;
                    end
                end
                TWM_ENG_START: begin
                    // Phase 2 waits for the released clock wire to read high
                    if (tick && (phase_q != 2'h2 || scl_s)) begin
                        phase_q <= phase_q + 2'h1;
                        unique case (phase_q)
                            2'h0: sda_low_q <= 1'b0;
                            2'h1: scl_low_q <= 1'b0;
                            2'h2: sda_low_q <= 1'b1;
                            2'h3: begin
                                scl_low_q <= 1'b1;
                                done_q <= 1'b1;
                                state_q <= TWM_ENG_IDLE;
                            end
                        endcase
                    end
                end
                TWM_ENG_STOP: begin
                    if (tick && (phase_q != 2'h2 || scl_s)) begin
                        phase_q <= phase_q + 2'h1;
                        unique case (phase_q)
                            2'h0: sda_low_q <= 1'b1;
                            2'h1: scl_low_q <= 1'b0;
                            2'h2: sda_low_q <= 1'b0;
                            2'h3: begin
                                done_q <= 1'b1;
                                state_q <= TWM_ENG_IDLE;
                            end
                        endcase
                    end
                end
                TWM_ENG_WRITE: begin
                    if (tick && (phase_q != 2'h2 || scl_s)) begin
                        phase_q <= phase_q + 2'h1;
                        unique case (phase_q)
                            2'h0: sda_low_q <= !shift_q[8];
                            2'h1: scl_low_q <= 1'b0;
                            2'h2: begin
                                // A released one read back as zero means another master won
                                if (bit_q != 4'h8 && shift_q[8] && !sda_s) begin
                                    scl_low_q <= 1'b0;
                                    sda_low_q <= 1'b0;
                                    arb_q <= 1'b1;
                                    done_q <= 1'b1;
                                    state_q <= TWM_ENG_IDLE;
                                end else if (bit_q == 4'h8) begin
                                    ack_q <= !sda_s;
                                end
                            end
                            2'h3: begin
                                scl_low_q <= 1'b1;
                                shift_q <= {shift_q[7:0], 1'b1};
                                bit_q <= bit_q + 4'h1;
                                if (bit_q == 4'h8) begin
                                    done_q <= 1'b1;
                                    state_q <= TWM_ENG_IDLE;
                                end
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    assign done = done_q;
    assign ack_seen = ack_q;
    assign arb_lost = arb_q;
    assign bus_busy = busy_q;
    assign scl_val = 1'b0;
    assign scl_oe = scl_low_q;
    assign sda_val = 1'b0;
    assign sda_oe = sda_low_q;

endmodule

`default_nettype wire

// file: hdl/twm_top.sv
// Two-wire master transmitter: register file, step sequencer and bit-rate divider
`timescale 1ns/10ps
`default_nettype none

`include "twm_params.svh"

module twm_top
    import twm_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Serial clock pin
    input wire logic scl_sense,
    output logic scl_val,
    output logic scl_oe,
    // Serial data pin
    input wire logic sda_sense,
    output logic sda_val,
    output logic sda_oe,
    // Interrupt request
    output logic irq
);

    // Control register bits
    logic done_flag_q;
    logic ack_en_q;
    logic start_req_q;
    logic stop_req_q;
    logic wcol_q;
    logic en_q;
    logic ie_q;
    // Other registers
    logic [1:0] presc_q;
    logic [7:0] rate_q;
    logic [7:0] data_q;
    logic [7:0] code_q;
    logic [7:0] rdata_q;
    // Sequencer
    twm_seq_t seq_q;
    twm_mode_t mode_q;
    logic own_q;
    logic addr_phase_q;
    logic cmd_valid_q;
    twm_cmd_t cmd_q;
    // Divider
    logic [14:0] div_cnt_q;
    logic [14:0] div_last;
    logic tick;
    // Engine answers
    logic eng_done;
    logic eng_ack;
    logic eng_arb;
    logic bus_busy;
    // Decoded register accesses
    logic ctl_wr;
    logic data_wr;
    logic resume;
    logic set_flag;
    logic [7:0] next_code;

    assign ctl_wr = reg_wr && reg_addr == `TWM_REG_CTRL;
    assign data_wr = reg_wr && reg_addr == `TWM_REG_DATA;
    assign resume = ctl_wr && reg_wdata[`TWM_CTL_DONE] && reg_wdata[`TWM_CTL_EN];

    ////////////////////////////////////////////////////////////////////////////
    // Bit-rate divider: quarter-bit tick every (rate+1) * 4^prescaler cycles

    assign div_last = ((15'(rate_q) + 15'h0001) << {presc_q, 1'b0}) - 15'h0001;

    always_ff @(posedge ref_clk) begin
        if (!rst_n || !en_q || div_cnt_q == div_last) begin
            div_cnt_q <= 15'h0000;
        end else begin
            div_cnt_q <= div_cnt_q + 15'h0001;
        end
    end

    assign tick = en_q && div_cnt_q == div_last;

    ////////////////////////////////////////////////////////////////////////////
    // Control register

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ack_en_q <= 1'b0;
            en_q <= 1'b0;
            ie_q <= 1'b0;
            start_req_q <= 1'b0;
        end else if (ctl_wr) begin
            ack_en_q <= reg_wdata[`TWM_CTL_ACK];
            en_q <= reg_wdata[`TWM_CTL_EN];
            ie_q <= reg_wdata[`TWM_CTL_IE];
            start_req_q <= reg_wdata[`TWM_CTL_STA];
        end
    end

    // Stop request clears itself once the STOP is on the wires
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            stop_req_q <= 1'b0;
        end else if (seq_q == TWM_SEQ_STOP && eng_done) begin
            stop_req_q <= 1'b0;
        end else if (ctl_wr) begin
            stop_req_q <= reg_wdata[`TWM_CTL_STO];
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            done_flag_q <= 1'b0;
        end else if (set_flag) begin
            done_flag_q <= 1'b1;
        end else if (ctl_wr && reg_wdata[`TWM_CTL_DONE]) begin
            done_flag_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data register and write collision

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            data_q <= `TWM_RST_DATA;
            wcol_q <= 1'b0;
        end else if (data_wr && !done_flag_q) begin
            wcol_q <= 1'b1;
        end else if (data_wr) begin
            data_q <= reg_wdata;
            wcol_q <= 1'b0;
        end
    end

    // Prescaler and bit rate
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            presc_q <= `TWM_RST_PRESC;
            rate_q <= `TWM_RST_RATE;
        end else if (reg_wr && reg_addr == `TWM_REG_STAT) begin
            presc_q <= reg_wdata[1:0];
        end else if (reg_wr && reg_addr == `TWM_REG_RATE) begin
            rate_q <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status code of the step just finished

    always_comb begin
        set_flag = 1'b0;
        next_code = code_q;
        if (eng_done) begin
            unique case (seq_q)
                TWM_SEQ_START: begin
                    set_flag = 1'b1;
                    next_code = own_q ? `TWM_ST_RSTART : `TWM_ST_START;
                end
                TWM_SEQ_ADDR: begin
                    set_flag = 1'b1;
                    if (eng_arb) begin
                        next_code = `TWM_ST_ARB_LOST;
                    end else if (data_q[0]) begin
                        next_code = eng_ack ? `TWM_ST_AR_ACK : `TWM_ST_AR_NACK;
                    end else begin
                        next_code = eng_ack ? `TWM_ST_AW_ACK : `TWM_ST_AW_NACK;
                    end
                end
                TWM_SEQ_DATA: begin
                    set_flag = 1'b1;
                    if (eng_arb) begin
                        next_code = `TWM_ST_ARB_LOST;
                    end else begin
                        next_code = eng_ack ? `TWM_ST_DATA_ACK : `TWM_ST_DATA_NACK;
                    end
                end
                default: begin
                    set_flag = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            code_q <= `TWM_ST_NONE;
        end else if (set_flag) begin
            code_q <= next_code;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Step sequencer: runs one step, or a STOP then a START, per flag clear, then waits

    // The write that sets enable may carry the first start request as well
    always_ff @(posedge ref_clk) begin
        if (!rst_n || (!en_q && !resume)) begin
            seq_q <= TWM_SEQ_IDLE;
            cmd_valid_q <= 1'b0;
            cmd_q <= TWM_CMD_NONE;
        end else begin
            cmd_valid_q <= 1'b0;
            unique case (seq_q)
                TWM_SEQ_IDLE: begin
                    if (resume && reg_wdata[`TWM_CTL_STO] && own_q) begin
                        seq_q <= TWM_SEQ_STOP;
                        cmd_q <= TWM_CMD_STOP;
                        cmd_valid_q <= 1'b1;
                    end else if (resume && reg_wdata[`TWM_CTL_STA] && own_q) begin
                        seq_q <= TWM_SEQ_START;
                        cmd_q <= TWM_CMD_START;
                        cmd_valid_q <= 1'b1;
                    end else if (resume && reg_wdata[`TWM_CTL_STA]) begin
                        seq_q <= TWM_SEQ_WAIT_FREE;
                    end else if (resume && own_q && mode_q != TWM_MODE_MR) begin
                        seq_q <= addr_phase_q ? TWM_SEQ_ADDR : TWM_SEQ_DATA;
                        cmd_q <= TWM_CMD_WRITE;
                        cmd_valid_q <= 1'b1;
                    end
                end
                TWM_SEQ_WAIT_FREE: begin
                    if (!bus_busy) begin
                        seq_q <= TWM_SEQ_START;
                        cmd_q <= TWM_CMD_START;
                        cmd_valid_q <= 1'b1;
                    end
                end
                TWM_SEQ_STOP: begin
                    if (eng_done) begin
                        seq_q <= start_req_q ? TWM_SEQ_WAIT_FREE : TWM_SEQ_IDLE;
                    end
                end
                TWM_SEQ_START, TWM_SEQ_ADDR, TWM_SEQ_DATA: begin
                    if (eng_done) begin
                        seq_q <= TWM_SEQ_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus ownership and operating mode

    always_ff @(posedge ref_clk) begin
        if (!rst_n || !en_q) begin
            own_q <= 1'b0;
            addr_phase_q <= 1'b0;
            mode_q <= TWM_MODE_IDLE;
        end else if (eng_done) begin
            unique case (seq_q)
                TWM_SEQ_START: begin
                    own_q <= 1'b1;
                    addr_phase_q <= 1'b1;
                end
                TWM_SEQ_STOP: begin
                    own_q <= 1'b0;
                    mode_q <= TWM_MODE_IDLE;
                end
                TWM_SEQ_ADDR, TWM_SEQ_DATA: begin
                    addr_phase_q <= 1'b0;
                    if (eng_arb) begin
                        own_q <= 1'b0;
                        mode_q <= TWM_MODE_SR;
                    end else if (seq_q == TWM_SEQ_ADDR) begin
                        mode_q <= data_q[0] ? TWM_MODE_MR : TWM_MODE_MT;
                    end
                end
                default: begin
                    own_q <= own_q;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bit engine

    twm_bit_engine u_engine (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .enable(en_q),
        .tick(tick),
        .cmd_valid(cmd_valid_q),
        .cmd(cmd_q),
        .tx_byte(data_q),
        .done(eng_done),
        .ack_seen(eng_ack),
        .arb_lost(eng_arb),
        .bus_busy(bus_busy),
        .scl_sense(scl_sense),
        .scl_val(scl_val),
        .scl_oe(scl_oe),
        .sda_sense(sda_sense),
        .sda_val(sda_val),
        .sda_oe(sda_oe)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read port, data one cycle after the strobe

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `TWM_REG_CTRL: rdata_q <= {done_flag_q, ack_en_q, start_req_q, stop_req_q,
                                           wcol_q, en_q, 1'b0, ie_q};
                // Code reads F8 whenever no step result is pending
                `TWM_REG_STAT: rdata_q <= ((done_flag_q ? code_q : `TWM_ST_NONE)
                                           & `TWM_STAT_MASK) | {6'h00, presc_q};
                `TWM_REG_DATA: rdata_q <= data_q;
                `TWM_REG_RATE: rdata_q <= rate_q;
            endcase
        end
    end

    assign reg_rdata = rdata_q;

    assign irq = done_flag_q && ie_q;

endmodule

`default_nettype wire

// file: tb/twm_assertions.sv
// Port-level checker of the two-wire master
`timescale 1ns/10ps
`default_nettype none
module twm_checker (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pins and interrupt
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic ctl_wr;
    assign ctl_wr = reg_wr && reg_addr == 2'h0;
    ////////////////////////////////////////////////////////////////
    reset_quiet_a: assert property (disable iff (1'b0)
        !rst_n |=> reg_rdata == 8'h00 && !scl_oe && !sda_oe && !irq)
        else $error("outputs active in reset");
    rdata_hold_a: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    stat_bit_a: assert property (reg_rd && reg_addr == 2'h1 |=> !reg_rdata[2])
        else $error("status bit 2 set");
    irq_mask_a: assert property (ctl_wr && !reg_wdata[0] |=> !irq)
        else $error("irq with enable clear");
    flag_clear_a: assert property (ctl_wr && reg_wdata[7] && irq |=> !irq)
        else $error("done flag not cleared");
    // Two cycles of grace let the last pin update of a step land
    step_hold_a: assert property (irq && $past(irq) && $past(irq, 2) |->
        $stable(scl_oe) && $stable(sda_oe))
        else $error("pins moved while suspended");
    start_go_a: assert property (ctl_wr && reg_wdata == 8'hA5 && !scl_oe |->
        ##[1:40] sda_oe)
        else $error("no start on free bus");
    abort_rel_a: assert property (ctl_wr && !reg_wdata[2] |=> ##[0:2] !scl_oe && !sda_oe)
        else $error("wires held after disable");
    cover property ($rose(irq));
    cover property ($fell(scl_oe));
    cover property (reg_wr && reg_addr == 2'h2 && !irq);
endmodule
bind twm_top twm_checker i_chk (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .scl_oe, .sda_oe, .irq);
`default_nettype wire

// file: tb/twm_slave_model.sv
// Behavioural slave receiver on the two wires
`timescale 1ns/10ps
`default_nettype none
module twm_slave_model (
    // Wires
    input wire logic scl,
    input wire logic sda,
    // Control and capture
    input wire logic nack,
    output logic ack_oe,
    output logic [7:0] rx_byte
);
    int n = 0;
    initial ack_oe = 1'b0;
    initial rx_byte = 8'h00;
    // Data falling with clock high is a start; the next clock fall opens bit one
    always @(negedge sda) if (scl) n = -1;
    always @(posedge scl) if (n < 8) rx_byte = {rx_byte[6:0], sda};
    always @(negedge scl) begin
        n = (n == 8) ? 0 : n + 1;
        ack_oe = (n == 8) && !nack;
    end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench of the two-wire master transmitter
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic nack = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata, rx, b;
    logic scl_val, scl_oe, sda_val, sda_oe, irq, s_oe;
    logic [7:0] rv[4] = '{8'h00, 8'hF8, 8'hFF, 8'h01};
    int miscompares = 0;
    int cmp_count = 0;
    int cyc = 0;
    // Both wires are pulled up
    wire logic scl_w = !scl_oe;
    wire logic sda_w = !(sda_oe || s_oe);
    twm_top i_dut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .scl_sense(scl_w), .scl_val, .scl_oe, .sda_sense(sda_w), .sda_val, .sda_oe, .irq);
    twm_slave_model i_slv (.scl(scl_w), .sda(sda_w), .nack, .ack_oe(s_oe), .rx_byte(rx));
    always #12.5 ref_clk = !ref_clk;
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
            miscompares++;
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata & m, e);
    endtask
    // Status is compared with the prescaler bits masked off
    task automatic step(input logic [7:0] c, input logic [7:0] e);
        wr(2'h0, c);
        @(negedge ref_clk);
        repeat (3000) if (irq !== 1'b1) @(negedge ref_clk);
        rd(2'h1, 8'hF8, e);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 30000) begin
            miscompares++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(83));
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) rd(2'(i), 8'hFF, rv[i]);
        b = 8'($urandom);
        wr(2'h3, b);
        rd(2'h3, 8'hFF, b);
        wr(2'h3, 8'h01);
        wr(2'h2, b);
        rd(2'h0, 8'hFF, 8'h08);
        rd(2'h2, 8'hFF, 8'hFF);
        $display("registers test done");
        step(8'hA5, 8'h08);
        b = 8'($urandom) & 8'hFE;
        wr(2'h2, b);
        rd(2'h0, 8'h08, 8'h00);
        step(8'h85, 8'h18);
        chk(rx, b);
        for (int k = 0; k < 3; k++) begin
            b = 8'($urandom);
            nack = (k == 2);
            wr(2'h2, b);
            step(8'h85, (k == 2) ? 8'h30 : 8'h28);
            chk(rx, b);
        end
        nack = 1'b0;
        $display("write burst test done");
        // Nonzero prescaler from here on, so the status masking really matters
        wr(2'h1, 8'h01);
        rd(2'h1, 8'h07, 8'h01);
        step(8'hA5, 8'h10);
        nack = 1'b1;
        wr(2'h2, 8'($urandom) & 8'hFE);
        step(8'h85, 8'h20);
        nack = 1'b0;
        step(8'hB5, 8'h08);
        rd(2'h0, 8'h10, 8'h00);
        wr(2'h2, 8'($urandom) | 8'h01);
        step(8'h85, 8'h40);
        $display("restart test done");
        wr(2'h0, 8'h95);
        @(negedge ref_clk);
        repeat (400) if (!(scl_w && sda_w)) @(negedge ref_clk);
        // The stop request clears one quarter bit after the data wire rises
        repeat (40) @(posedge ref_clk);
        rd(2'h0, 8'hFF, 8'h05);
        wr(2'h0, 8'h00);
        rd(2'h0, 8'hFF, 8'h00);
        chk({4'h0, scl_val, sda_val, scl_w, sda_w}, 8'h03);
        $display("stop test done");
        complete_run();
    end
endmodule
`default_nettype wire
